//--- rtl/pbo_port_b.sv
// Port B pin logic with alternate-function overrides for six pins.
// Assumes peripheral controls arrive on the system clock; pad inputs are
// asynchronous and are synchronised before use.
// Functional notes
// - Serial slave mode forces pin 0 to input.
// - Serial master mode leaves pin 0 direction to its direction bit.
// - Slave-forced pin 0 pull-up still follows its latch bit.
// - Timer 0 compare A reaches pin 0 only when direction bit set.
// - Inverted timer 1 compare B may drive pin 3 as output.
// - Analog reference use disables pin 0 pull-up and driver.
// - Three-wire data input needs software to make pin 0 an input.
// - Pin 5 input override from reset fuse, pin change, analog disable.
// - Pin 4 input override from pin change, analog 2; compare B drives.
// - Pin 2 input override from pin change, analog 1, start irq enable.
// - Pin 1 input override from pin change or comparator-neg disable.
// - Pin 0 input override from pin change, comparator-pos, start irq.
// - Two-wire pin 0 pull-up off, direction from data or latch.
// - Pin 0 output override from compare enables or two-wire mode.
// - Global pull-up disable switches off every pull-up.
// - Reset pin use: pull-up on, driver and digital input off.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module pbo_port_b #(
  parameter int NPINS = pbo_pkg::PBO_NPINS
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Fuses, raw levels (zero means programmed)
  input wire logic RESET_PIN_DISABLE_FUSE_I,
  input wire logic DEBUG_LINK_ENABLE_FUSE_I,
  input wire logic DEBUG_LINK_TX_I,
  // Serial interface controls
  input wire logic SPI_ENABLE_I,
  input wire logic SPI_MASTER_I,
  input wire logic SERIAL_IF_TWO_WIRE_MODE_I,
  input wire logic SERIAL_IF_THREE_WIRE_MODE_I,
  input wire logic SERIAL_IF_CLOCK_HOLD_I,
  input wire logic SERIAL_IF_CLOCK_TOGGLE_I,
  input wire logic SERIAL_IF_START_IRQ_ENABLE_I,
  input wire logic SERIAL_IF_DATA_OUT_I,
  input wire logic SERIAL_IF_SDA_OUT_I,
  // Timer compare outputs and enables
  input wire logic TIMER0_COMPARE_A_OUT_I,
  input wire logic TIMER0_COMPARE_A_EN_I,
  input wire logic TIMER0_COMPARE_B_OUT_I,
  input wire logic TIMER0_COMPARE_B_EN_I,
  input wire logic TIMER1_COMPARE_A_OUT_I,
  input wire logic TIMER1_COMPARE_A_EN_I,
  input wire logic TIMER1_COMPARE_B_OUT_I,
  input wire logic TIMER1_COMPARE_B_EN_I,
  input wire logic TIMER1_COMPARE_B_INV_I,
  // Analog and pin-change controls
  input wire logic ANALOG_REFERENCE_PIN_I,
  input wire logic ANALOG_IN0_DIGITAL_DISABLE_I,
  input wire logic ANALOG_IN1_DIGITAL_DISABLE_I,
  input wire logic ANALOG_IN2_DIGITAL_DISABLE_I,
  input wire logic ANALOG_IN3_DIGITAL_DISABLE_I,
  input wire logic COMPARATOR_NEG_DIGITAL_DISABLE_I,
  input wire logic COMPARATOR_POS_DIGITAL_DISABLE_I,
  input wire logic [5:0] PIN_CHANGE_SRC_I,
  input wire logic PIN_CHANGE_IRQ_ENABLE_I,
  // Pads
  input wire logic [5:0] PAD_IN_I,
  output logic [5:0] PAD_OUT_O,
  output logic [5:0] PAD_OE_O,
  output logic [5:0] PAD_PULLUP_O,
  // Synchronised, input-enable gated levels to peripherals
  output logic [5:0] PIN_LEVEL_O
);
  import pbo_pkg::*;

  // Every override equation below is written for exactly six pins
  if (NPINS != 6) begin : g_npins_check
    $error("pbo_port_b serves exactly six pins");
  end

  logic [5:0] dir_r;
  logic [5:0] latch_r;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] level_r;
  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;

  // Register decode
  wire sel_in = (REG_ADDR_I == PBO_OFF_INPUT);
  wire sel_dir = (REG_ADDR_I == PBO_OFF_DIR);
  wire sel_lat = (REG_ADDR_I == PBO_OFF_LATCH);
  wire sel_ctl = (REG_ADDR_I == PBO_OFF_CTRL);
  wire pullup_global_disable = ctrl_r[PBO_PUD_BIT];

  // Write enables; the address alone never changes state
  wire wr_in = REG_WR_I & sel_in;
  wire wr_dir = REG_WR_I & sel_dir;
  wire wr_lat = REG_WR_I & sel_lat;
  wire wr_ctl = REG_WR_I & sel_ctl;

  // Fuse terms: one when the fuse is programmed
  wire rst_fuse = ~RESET_PIN_DISABLE_FUSE_I;
  wire dbg_fuse = ~DEBUG_LINK_ENABLE_FUSE_I;
  wire tw = SERIAL_IF_TWO_WIRE_MODE_I;
  wire spi_slave = SPI_ENABLE_I & ~SPI_MASTER_I;

  // Override enables and values per pin
  logic [5:0] pullup_override_enable;
  logic [5:0] pullup_override_value;
  logic [5:0] direction_override_enable;
  logic [5:0] direction_override_value;
  logic [5:0] out_value_override_enable;
  logic [5:0] out_value_override_value;
  logic [5:0] toggle_override_enable;
  logic [5:0] input_enable_override_enable;
  logic [5:0] input_enable_override_value;
  wire [5:0] pcint = PIN_CHANGE_SRC_I & {6{PIN_CHANGE_IRQ_ENABLE_I}};

  // Pin 5: reset pin when the reset-disable fuse is unprogrammed
  wire reset_use = ~rst_fuse;
  assign pullup_override_enable[5] = (rst_fuse & dbg_fuse) | reset_use;
  assign pullup_override_value[5] = 1'b1;
  assign direction_override_enable[5] = (rst_fuse & dbg_fuse) | reset_use;
  assign direction_override_value[5] = reset_use ? 1'b0 : DEBUG_LINK_TX_I;
  assign out_value_override_enable[5] = reset_use;
  assign out_value_override_value[5] = 1'b0;
  // Pin 5 input override; reset use turns the digital input off
  assign input_enable_override_enable[5] = rst_fuse | reset_use
    | pcint[5] | ANALOG_IN0_DIGITAL_DISABLE_I;
  // Override value one means input off, as for the analog disables
  assign input_enable_override_value[5] = reset_use ? 1'b1
    : ANALOG_IN0_DIGITAL_DISABLE_I;

  // Pin 4: timer 1 compare B
  assign pullup_override_enable[4] = 1'b0;
  assign pullup_override_value[4] = 1'b0;
  assign direction_override_enable[4] = 1'b0;
  assign direction_override_value[4] = 1'b0;
  assign out_value_override_enable[4] = TIMER1_COMPARE_B_EN_I;
  assign out_value_override_value[4] = TIMER1_COMPARE_B_OUT_I;
  assign input_enable_override_enable[4] = pcint[4]
    | ANALOG_IN2_DIGITAL_DISABLE_I;
  assign input_enable_override_value[4] = ANALOG_IN2_DIGITAL_DISABLE_I;

  // Pin 3: inverted timer 1 compare B
  assign pullup_override_enable[3] = 1'b0;
  assign pullup_override_value[3] = 1'b0;
  assign direction_override_enable[3] = 1'b0;
  assign direction_override_value[3] = 1'b0;
  assign out_value_override_enable[3] = TIMER1_COMPARE_B_INV_I;
  assign out_value_override_value[3] = ~TIMER1_COMPARE_B_OUT_I;
  assign input_enable_override_enable[3] = pcint[3]
    | ANALOG_IN3_DIGITAL_DISABLE_I;
  assign input_enable_override_value[3] = ANALOG_IN3_DIGITAL_DISABLE_I;

  // Pin 2: two-wire clock, open drain with hold
  assign pullup_override_enable[2] = tw;
  assign pullup_override_value[2] = 1'b0;
  assign direction_override_enable[2] = tw;
  assign direction_override_value[2] =
    (SERIAL_IF_CLOCK_HOLD_I | latch_r[2]) & dir_r[2];
  assign out_value_override_enable[2] = tw & dir_r[2];
  assign out_value_override_value[2] = 1'b0;
  assign input_enable_override_enable[2] = pcint[2]
    | ANALOG_IN1_DIGITAL_DISABLE_I
    | SERIAL_IF_START_IRQ_ENABLE_I;
  assign input_enable_override_value[2] = ANALOG_IN1_DIGITAL_DISABLE_I;

  // Pin 1: compare outputs and three-wire data out
  assign pullup_override_enable[1] = 1'b0;
  assign pullup_override_value[1] = 1'b0;
  assign direction_override_enable[1] = 1'b0;
  assign direction_override_value[1] = 1'b0;
  assign out_value_override_enable[1] = TIMER0_COMPARE_B_EN_I
    | TIMER1_COMPARE_A_EN_I | SERIAL_IF_THREE_WIRE_MODE_I;
  assign out_value_override_value[1] = TIMER0_COMPARE_B_OUT_I
    | TIMER1_COMPARE_A_OUT_I | SERIAL_IF_DATA_OUT_I;
  assign input_enable_override_enable[1] = pcint[1]
    | COMPARATOR_NEG_DIGITAL_DISABLE_I;
  assign input_enable_override_value[1] =
    COMPARATOR_NEG_DIGITAL_DISABLE_I;

  // Pin 0: data pin; analog reference wins over everything else
  // Slave forcing only touches direction, so the pull-up keeps the latch
  wire p0_ref = ANALOG_REFERENCE_PIN_I;
  assign pullup_override_enable[0] = tw | p0_ref;
  assign pullup_override_value[0] = 1'b0;
  assign direction_override_enable[0] = tw | p0_ref
    | spi_slave;
  assign direction_override_value[0] = (p0_ref | spi_slave) ? 1'b0
    : ((SERIAL_IF_SDA_OUT_I | latch_r[0]) & dir_r[0]);
  assign out_value_override_enable[0] = TIMER0_COMPARE_A_EN_I
    | TIMER1_COMPARE_A_EN_I | (tw & dir_r[0]);
  assign out_value_override_value[0] = TIMER0_COMPARE_A_OUT_I
    | TIMER1_COMPARE_A_OUT_I;
  assign input_enable_override_enable[0] = pcint[0]
    | COMPARATOR_POS_DIGITAL_DISABLE_I
    | SERIAL_IF_START_IRQ_ENABLE_I;
  assign input_enable_override_value[0] = COMPARATOR_POS_DIGITAL_DISABLE_I;

  // Toggle override only on pin 2; it flips the latch below
  assign toggle_override_enable = {3'b000, SERIAL_IF_CLOCK_TOGGLE_I, 2'b00};

  // Per-pin selection between override and register values
  logic [5:0] eff_dir, eff_out, eff_pu, eff_ie;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      // Pull-up follows the latch even where slave mode forces pin 0 to input
      wire reg_pu = latch_r[g] & ~pullup_global_disable;
      assign eff_dir[g] = direction_override_enable[g]
        ? direction_override_value[g] : dir_r[g];
      assign eff_out[g] = out_value_override_enable[g]
        ? out_value_override_value[g] : latch_r[g];
      // Global disable beats both the register and override pull-ups
      assign eff_pu[g] = ~pullup_global_disable & ~eff_dir[g]
        & (pullup_override_enable[g] ? pullup_override_value[g]
        : reg_pu);
      // An override value of one turns the digital input off
      assign eff_ie[g] = input_enable_override_enable[g]
        ? input_enable_override_value[g] == 1'b0 : 1'b1;
    end
  endgenerate

  // Pad controls stay combinational so overrides act at once
  assign PAD_OUT_O = eff_out;
  assign PAD_OE_O = eff_dir;
  assign PAD_PULLUP_O = eff_pu;
  assign PIN_LEVEL_O = level_r;
  assign REG_RDATA_O = rdata_r;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux = sel_in ? {2'b00, sync2_r}
    : sel_dir ? {2'b00, dir_r}
    : sel_lat ? {2'b00, latch_r}
    : sel_ctl ? ctrl_r : 8'h00;

  // Writing one to the input register toggles the latch bit
  wire [5:0] pin_toggle = wr_in ? REG_WDATA_I[5:0] : 6'h00;
  wire [5:0] latch_nxt = wr_lat ? REG_WDATA_I[5:0]
    : latch_r ^ pin_toggle ^ toggle_override_enable;

  // Next values; read-only control bits are masked on the way in
  wire [5:0] dir_nxt = wr_dir ? REG_WDATA_I[5:0] : dir_r;
  wire [7:0] ctrl_nxt = wr_ctl ? (REG_WDATA_I & PBO_CTRL_WMASK)
    : ctrl_r;
  wire [7:0] rdata_nxt = REG_RD_I ? rd_mux : 8'h00;

  // Pad synchroniser; first stage read only by the second
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      level_r <= 6'h00;
    end else begin
      sync1_r <= PAD_IN_I;
      sync2_r <= sync1_r;
      level_r <= sync2_r & eff_ie;
    end
  end

  // Direction bits; reset leaves every pin an input
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dir_r <= PBO_DIR_RST[5:0];
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // Output latch; a software write beats a toggle in the same cycle
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      latch_r <= PBO_LATCH_RST[5:0];
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Control register holding the global pull-up disable
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_r <= PBO_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
endmodule

//--- rtl/pbo_pkg.sv
// Port B override logic: register offsets, field positions, reset values.
// Assumes an 8-bit register port with byte offsets as printed.
package pbo_pkg;
  localparam int PBO_NPINS = 6;
  localparam logic [7:0] PBO_OFF_INPUT = 8'h16;
  localparam logic [7:0] PBO_OFF_DIR = 8'h17;
  localparam logic [7:0] PBO_OFF_LATCH = 8'h18;
  localparam logic [7:0] PBO_OFF_CTRL = 8'h35;
  localparam logic [7:0] PBO_DIR_RST = 8'h00;
  localparam logic [7:0] PBO_LATCH_RST = 8'h00;
  localparam logic [7:0] PBO_CTRL_RST = 8'h00;
  localparam logic [7:0] PBO_CTRL_WMASK = 8'h7B;
  localparam int PBO_PUD_BIT = 6;
endpackage

//--- tb/pbo_chk_asserts.sv
// Checker for the port B override block: pad and register relations.
// Sees only top-level ports; shadows direction and latch from writes.
`timescale 1ns/100ps
module pbo_chk
  import pbo_pkg::*;
#(parameter int NPINS = 6)
(
  // Clock, reset and register port
  input wire logic CLK_SYS_I, SYS_RST_I, REG_WR_I, REG_RD_I,
  input wire logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
  // Peripheral controls
  input wire logic SPI_ENABLE_I, SPI_MASTER_I, SERIAL_IF_SDA_OUT_I,
  input wire logic SERIAL_IF_TWO_WIRE_MODE_I, ANALOG_REFERENCE_PIN_I,
  input wire logic TIMER0_COMPARE_A_OUT_I, TIMER0_COMPARE_A_EN_I,
  input wire logic TIMER1_COMPARE_A_OUT_I, TIMER1_COMPARE_A_EN_I,
  input wire logic TIMER1_COMPARE_B_INV_I, RESET_PIN_DISABLE_FUSE_I,
  // Pads
  input wire logic [5:0] PAD_OUT_O, PAD_OE_O, PAD_PULLUP_O, PIN_LEVEL_O
);
  logic [7:0] dir_r, lat_r;
  wire wr_dir = REG_WR_I && REG_ADDR_I == PBO_OFF_DIR;
  wire wr_lat = REG_WR_I && REG_ADDR_I == PBO_OFF_LATCH;
  wire wr_pin = REG_WR_I && REG_ADDR_I == PBO_OFF_INPUT;
  // Shadows; clock-toggle on bit 2 is not followed, bit 2 is unused here
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dir_r <= 8'h00;
      lat_r <= 8'h00;
    end else begin
      if (wr_dir) dir_r <= REG_WDATA_I;
      if (wr_lat) lat_r <= REG_WDATA_I;
      else if (wr_pin) lat_r <= lat_r ^ REG_WDATA_I;
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  AST_ANALOG_REFERENCE_PIN_QUIET: assert property (
    ANALOG_REFERENCE_PIN_I |-> !PAD_OE_O[0] && !PAD_PULLUP_O[0])
    else $error("reference pin still driven or pulled");
  AST_SLAVE_INPUT: assert property (
    SPI_ENABLE_I && !SPI_MASTER_I && !SERIAL_IF_TWO_WIRE_MODE_I
    |-> !PAD_OE_O[0]) else $error("slave pin 0 driven");
  AST_TWO_WIRE_DATA: assert property (
    SERIAL_IF_TWO_WIRE_MODE_I && !ANALOG_REFERENCE_PIN_I && !SPI_ENABLE_I
    |-> !PAD_PULLUP_O[0] && PAD_OE_O[0] ==
    ((SERIAL_IF_SDA_OUT_I | lat_r[0]) & dir_r[0]))
    else $error("two-wire data pin wrong");
  AST_COMPARE_OUT: assert property (
    TIMER0_COMPARE_A_EN_I || TIMER1_COMPARE_A_EN_I |-> PAD_OUT_O[0] ==
    (TIMER0_COMPARE_A_OUT_I | TIMER1_COMPARE_A_OUT_I))
    else $error("compare value missing on pin 0");
  AST_PULLUP_KILL: assert property (
    REG_WR_I && REG_ADDR_I == PBO_OFF_CTRL && REG_WDATA_I[PBO_PUD_BIT]
    |=> PAD_PULLUP_O == 6'h00) else $error("pull-up left on");
  AST_PLAIN_PIN3: assert property (
    !TIMER1_COMPARE_B_INV_I |-> PAD_OE_O[3] == dir_r[3] &&
    PAD_OUT_O[3] == lat_r[3]) else $error("pin 3 not from registers");
  AST_DIR_READ: assert property (
    REG_RD_I && REG_ADDR_I == PBO_OFF_DIR
    |=> REG_RDATA_O == {2'b00, dir_r[5:0]}) else $error("dir read wrong");
  AST_RESET_PIN: assert property (
    RESET_PIN_DISABLE_FUSE_I [*4] |-> !PIN_LEVEL_O[5] && !PAD_OE_O[5])
    else $error("reset pin driven or read");
endmodule
bind pbo_port_b pbo_chk #(.NPINS(NPINS)) i_pbo_chk (
  .CLK_SYS_I, .SYS_RST_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_RDATA_O, .SPI_ENABLE_I, .SPI_MASTER_I,
  .SERIAL_IF_SDA_OUT_I, .SERIAL_IF_TWO_WIRE_MODE_I,
  .ANALOG_REFERENCE_PIN_I, .TIMER0_COMPARE_A_OUT_I,
  .TIMER0_COMPARE_A_EN_I, .TIMER1_COMPARE_A_OUT_I,
  .TIMER1_COMPARE_A_EN_I, .TIMER1_COMPARE_B_INV_I,
  .RESET_PIN_DISABLE_FUSE_I, .PAD_OUT_O, .PAD_OE_O, .PAD_PULLUP_O,
  .PIN_LEVEL_O);

//--- tb/pbo_pad_model.sv
// Pad and far-side model for port B: resolves each pad's level.
// Assumes the block drives when its enable is high.
`timescale 1ns/100ps
module pbo_pad_model (
  // Clock
  input wire logic clk_i,
  // Block side and far-side drivers
  input wire logic [5:0] out_i, oe_i, pu_i, ext_en_i, ext_val_i,
  // Resolved levels
  output logic [5:0] pad_o
);
  logic [5:0] last_r = 6'h00;
  // Block wins, then far side, then pull-up; a bare pin flips each cycle
  always_comb
    for (int i = 0; i < 6; i++)
      pad_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                 pu_i[i] ? 1'b1 : ~last_r[i];
  always_ff @(posedge clk_i) last_r <= pad_o;
endmodule

//--- tb/port_b_alt_function_override_test.sv
// Self-checking bench for the port B override block.
// Pads resolved by the pad model; expectations from a bench model.
`timescale 1ns/100ps
module port_b_alt_function_override_test;
  import pbo_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rf = 0, df = 1, tog = 0;
  logic [7:0] adr = 0, wd = 0, rdat;
  logic [25:0] pv = 0;
  logic [5:0] pcs = 0, xen = 0, xv = 0, pin, po, poe, ppu, plv, dis;
  logic [7:0] ad[4] = '{PBO_OFF_DIR, PBO_OFF_LATCH, PBO_OFF_CTRL, 8'h20};
  int n_fail = 0, n_checks = 0, cyc = 0, dir = 0, lat = 0, ctl = 0;
  logic [31:0] r;
  pbo_port_b #(.NPINS(PBO_NPINS)) i_pbo_port_b (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(adr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .RESET_PIN_DISABLE_FUSE_I(rf), .DEBUG_LINK_ENABLE_FUSE_I(df),
    .SPI_ENABLE_I(pv[0]), .SPI_MASTER_I(pv[1]),
    .SERIAL_IF_TWO_WIRE_MODE_I(pv[2]), .SERIAL_IF_THREE_WIRE_MODE_I(pv[3]),
    .SERIAL_IF_CLOCK_HOLD_I(pv[4]), .SERIAL_IF_CLOCK_TOGGLE_I(tog),
    .SERIAL_IF_START_IRQ_ENABLE_I(pv[5]), .SERIAL_IF_DATA_OUT_I(pv[6]),
    .SERIAL_IF_SDA_OUT_I(pv[7]), .TIMER0_COMPARE_A_OUT_I(pv[8]),
    .TIMER0_COMPARE_A_EN_I(pv[9]), .TIMER0_COMPARE_B_OUT_I(pv[10]),
    .TIMER0_COMPARE_B_EN_I(pv[11]), .TIMER1_COMPARE_A_OUT_I(pv[12]),
    .TIMER1_COMPARE_A_EN_I(pv[13]), .TIMER1_COMPARE_B_OUT_I(pv[14]),
    .TIMER1_COMPARE_B_EN_I(pv[15]), .TIMER1_COMPARE_B_INV_I(pv[16]),
    .ANALOG_REFERENCE_PIN_I(pv[17]), .ANALOG_IN0_DIGITAL_DISABLE_I(pv[18]),
    .ANALOG_IN1_DIGITAL_DISABLE_I(pv[19]),
    .ANALOG_IN2_DIGITAL_DISABLE_I(pv[20]),
    .ANALOG_IN3_DIGITAL_DISABLE_I(pv[21]),
    .COMPARATOR_NEG_DIGITAL_DISABLE_I(pv[22]),
    .COMPARATOR_POS_DIGITAL_DISABLE_I(pv[23]), .PIN_CHANGE_SRC_I(pcs),
    .PIN_CHANGE_IRQ_ENABLE_I(pv[24]), .DEBUG_LINK_TX_I(pv[25]),
    .PAD_IN_I(pin), .PAD_OUT_O(po), .PAD_OE_O(poe), .PAD_PULLUP_O(ppu),
    .PIN_LEVEL_O(plv));
  pbo_pad_model i_pbo_pad_model (.clk_i(clk), .out_i(po), .oe_i(poe),
    .pu_i(ppu), .ext_en_i(xen), .ext_val_i(xv), .pad_o(pin));
  initial forever #2 clk = ~clk;
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register model: what a read of each address should return
  function automatic logic [7:0] ev(logic [7:0] a);
    return a == PBO_OFF_DIR ? 8'(dir) : a == PBO_OFF_LATCH ? 8'(lat) :
      a == PBO_OFF_CTRL ? 8'(ctl) :
      a == PBO_OFF_INPUT ? {2'b00, xv & 6'h1F} : 8'h00;
  endfunction
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    if (a == PBO_OFF_DIR) dir = d & 8'h3F;
    if (a == PBO_OFF_LATCH) lat = d & 8'h3F;
    if (a == PBO_OFF_INPUT) lat ^= d & 8'h3F;
    if (a == PBO_OFF_CTRL) ctl = d & PBO_CTRL_WMASK;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(a == PBO_OFF_INPUT ? rdat & 8'h1F : rdat, ev(a));
  endtask
  // Pin 0 model: reference, two-wire, slave, then plain direction
  task automatic pin0;
    logic d, l, tw, oe, pu, en;
    d = dir[0];
    l = lat[0];
    tw = pv[2];
    oe = pv[17] ? 0 : tw ? (pv[7] | l) & d : (pv[0] & !pv[1]) ? 0 : d;
    pu = (pv[17] | tw | ctl[6]) ? 0 : l & !oe;
    en = pv[9] | pv[13] | (tw & d);
    #1 chk({poe[0], ppu[0]}, {oe, pu});
    chk(po[0], en ? pv[8] | pv[12] : l);
    // Pin 2: two-wire clock is open drain with hold
    d = dir[2];
    l = lat[2];
    oe = tw ? (pv[4] | l) & d : d;
    pu = (tw | ctl[6]) ? 0 : l & !oe;
    chk({poe[2], ppu[2], po[2]}, {oe, pu, !(tw & d) & l});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h297b));
    repeat (16) @(posedge clk);
    rst <= 0;
    foreach (ad[i]) rreg(ad[i]);
    // Plain pins with random registers, toggles and unmapped writes
    repeat (8) begin
      wreg(PBO_OFF_DIR, 8'($urandom));
      wreg(PBO_OFF_LATCH, 8'($urandom));
      wreg(PBO_OFF_CTRL, 8'($urandom));
      wreg(8'h20, 8'($urandom));
      wreg(PBO_OFF_INPUT, 8'($urandom));
      foreach (ad[i]) rreg(ad[i]);
      chk(poe, dir);
      chk(po, lat);
      chk(ppu, ctl[6] ? 0 : lat & ~dir);
    end
    // Random overrides against the pin 0 model
    repeat (32) begin
      r = $urandom;
      r[0] = r[0] & !r[2];
      @(posedge clk);
      pv <= r[25:0];
      wreg(PBO_OFF_DIR, 8'($urandom));
      wreg(PBO_OFF_LATCH, 8'($urandom));
      wreg(PBO_OFF_CTRL, 8'($urandom));
      pin0;
    end
    // Far side drives inputs, pins left as inputs, pull-ups off
    @(posedge clk);
    pv <= 26'h8;
    wreg(PBO_OFF_DIR, 8'h00);
    wreg(PBO_OFF_LATCH, 8'h00);
    wreg(PBO_OFF_CTRL, 8'h00);
    repeat (4) begin
      @(posedge clk);
      xv <= 6'($urandom);
      xen <= 6'h3F;
      pcs <= 6'($urandom);
      pv <= {1'b0, 7'($urandom), 12'h000, 1'($urandom), 5'h08};
      repeat (4) @(posedge clk);
      // Only the digital disables turn an input off
      dis = {pv[18], pv[20], pv[21], pv[19], pv[22], pv[23]};
      #1 chk(plv, xv & ~dis);
      rreg(PBO_OFF_INPUT);
    end
    // Clock toggle strobe high for one cycle flips latch bit 2
    @(posedge clk);
    tog <= 1;
    @(posedge clk);
    tog <= 0;
    lat ^= 8'h04;
    rreg(PBO_OFF_LATCH);
    @(posedge clk);
    xen <= 0;
    rf <= 1;
    repeat (6) @(posedge clk);
    #1 chk({ppu[5], poe[5], plv[5]}, 3'b100);
    tally_and_finish;
  end
endmodule
